/* rtl/aop_top.v */
`timescale 1ns/1ns
`include "aop_defs.vh"
module aop_top #(
  parameter WORD_W = `AOP_WORD_W,
  parameter PD_RECOVER_NS = `AOP_PD_RECOVER_NS,
  parameter SLEEP_RECOVER_NS = `AOP_SLEEP_RECOVER_NS
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // sampling clock pins
  input wire sample_clk_p,
  input wire sample_clk_n,
  // raw code from the converter core
  input wire signed [`AOP_RAW_W-1:0] raw_code,
  // multi-level strap pins, as level codes
  input wire [1:0] power_mode_pin,
  input wire [1:0] clock_and_format_pin,
  // differential output port
  output reg [WORD_W-1:0] conversion_word_lanes_p,
  output reg [WORD_W-1:0] conversion_word_lanes_n,
  output reg over_range_p,
  output reg over_range_n,
  output reg forwarded_word_clock_p,
  output reg forwarded_word_clock_n,
  // analog control levels
  output reg reference_on,
  output reg core_sleep,
  output reg core_power_down,
  output reg clock_differential,
  // avalon-mm slave
  input wire [`AOP_ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [`AOP_DATA_W-1:0] writedata,
  output reg [`AOP_DATA_W-1:0] readdata,
  output wire waitrequest,
  // interrupt
  output wire irq
);

  localparam integer PD_CYC = (PD_RECOVER_NS + `AOP_CLK_NS - 1) / `AOP_CLK_NS;
  localparam integer SLEEP_CYC = (SLEEP_RECOVER_NS + `AOP_CLK_NS - 1) / `AOP_CLK_NS;

  // power states, one-hot
  localparam [3:0] ST_NORMAL = 4'h1;
  localparam [3:0] ST_SLEEP = 4'h2;
  localparam [3:0] ST_PD = 4'h4;
  localparam [3:0] ST_WAKE = 4'h8;

  // synchronised pins
  wire [1:0] clk_pins_s;
  wire [1:0] pm_s;
  wire [1:0] cf_s;
  wire [`AOP_RAW_W-1:0] raw_s;

  aop_sync #(
    .W(`AOP_RAW_W + 6)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({sample_clk_n, sample_clk_p, power_mode_pin, clock_and_format_pin, raw_code}),
    .sync_out({clk_pins_s, pm_s, cf_s, raw_s})
  );

  // strap decode
  reg want_pd;
  reg want_sleep;
  reg diff_sel;
  reg twos_sel;

  always @* begin
    want_pd = 1'b0;
    want_sleep = 1'b0;
    case (pm_s)
      `AOP_LVL_FULL: begin
        want_pd = 1'b1;
      end
      `AOP_LVL_TWO_THIRDS: begin
        want_sleep = 1'b1;
      end
      default: begin
        want_pd = 1'b0;
      end
    endcase
  end

  always @* begin
    case (cf_s)
      `AOP_LVL_FULL: begin
        diff_sel = 1'b1;
        twos_sel = 1'b1;
      end
      `AOP_LVL_TWO_THIRDS: begin
        diff_sel = 1'b1;
        twos_sel = 1'b0;
      end
      `AOP_LVL_THIRD: begin
        diff_sel = 1'b0;
        twos_sel = 1'b1;
      end
      default: begin
        diff_sel = 1'b0;
        twos_sel = 1'b0;
      end
    endcase
  end

  // negative pin assumed grounded in single-ended mode
  wire samp_level = diff_sel ? (clk_pins_s[0] & ~clk_pins_s[1]) : clk_pins_s[0];
  reg samp_prev;
  wire samp_rise = samp_level & ~samp_prev;
  wire samp_fall = ~samp_level & samp_prev;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      samp_prev <= 1'b0;
    end else begin
      samp_prev <= samp_level;
    end
  end

  // registers
  reg [1:0] ctrl;
  reg [`AOP_ST_W-1:0] status;
  reg [`AOP_ST_W-1:0] mask;
  reg [`AOP_DATA_W-1:0] word_count;
  reg [WORD_W-1:0] last_word;
  reg last_over;
  reg bus_ack;

  // power state machine
  reg [3:0] pstate;
  reg [3:0] next_pstate;
  reg [`AOP_CNT_W-1:0] wake_cnt;
  reg [`AOP_CNT_W-1:0] next_wake_cnt;
  wire go_pd = want_pd | ctrl[`AOP_CTRL_FORCE_PD];

  always @* begin
    next_pstate = pstate;
    next_wake_cnt = wake_cnt;
    case (pstate)
      ST_NORMAL: begin
        if (go_pd) begin
          next_pstate = ST_PD;
        end else if (want_sleep) begin
          next_pstate = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (go_pd) begin
          next_pstate = ST_PD;
        end else if (!want_sleep) begin
          next_pstate = ST_WAKE;
          next_wake_cnt = SLEEP_CYC[`AOP_CNT_W-1:0];
        end
      end
      ST_PD: begin
        if (!go_pd) begin
          next_pstate = want_sleep ? ST_SLEEP : ST_WAKE;
          next_wake_cnt = PD_CYC[`AOP_CNT_W-1:0];
        end
      end
      ST_WAKE: begin
        if (go_pd) begin
          next_pstate = ST_PD;
        end else if (want_sleep) begin
          next_pstate = ST_SLEEP;
        end else if (wake_cnt <= 1) begin
          next_pstate = ST_NORMAL;
          next_wake_cnt = {`AOP_CNT_W{1'b0}};
        end else begin
          next_wake_cnt = wake_cnt - 1'b1;
        end
      end
      default: begin
        next_pstate = ST_PD;
        next_wake_cnt = {`AOP_CNT_W{1'b0}};
      end
    endcase
  end

  // power-down at reset mirrors a fresh power-up
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pstate <= ST_PD;
      wake_cnt <= {`AOP_CNT_W{1'b0}};
    end else begin
      pstate <= next_pstate;
      wake_cnt <= next_wake_cnt;
    end
  end

  wire running = (pstate == ST_NORMAL) & ctrl[`AOP_CTRL_EN];

  // formatter
  wire [WORD_W-1:0] fmt_word;
  wire fmt_over;

  aop_fmt u_fmt (
    .raw_code(raw_s),
    .twos_sel(twos_sel),
    .word(fmt_word),
    .over_range(fmt_over)
  );

  // output port
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conversion_word_lanes_p <= {WORD_W{1'b0}};
      conversion_word_lanes_n <= {WORD_W{1'b1}};
      over_range_p <= 1'b0;
      over_range_n <= 1'b1;
      forwarded_word_clock_p <= 1'b0;
      forwarded_word_clock_n <= 1'b1;
    end else if (!running) begin
      // clock parked low, no words while idle
      forwarded_word_clock_p <= 1'b0;
      forwarded_word_clock_n <= 1'b1;
    end else if (samp_rise) begin
      conversion_word_lanes_p <= fmt_word;
      conversion_word_lanes_n <= ~fmt_word;
      over_range_p <= fmt_over;
      over_range_n <= ~fmt_over;
      forwarded_word_clock_p <= 1'b0;
      forwarded_word_clock_n <= 1'b1;
    end else if (samp_fall) begin
      forwarded_word_clock_p <= 1'b1;
      forwarded_word_clock_n <= 1'b0;
    end
  end

  // analog control levels
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reference_on <= 1'b1;
      core_sleep <= 1'b0;
      core_power_down <= 1'b1;
      clock_differential <= 1'b0;
    end else begin
      reference_on <= 1'b1;
      core_sleep <= (pstate == ST_SLEEP);
      core_power_down <= (pstate == ST_PD);
      clock_differential <= diff_sel;
    end
  end

  // events
  reg [1:0] pm_prev;
  reg [1:0] cf_prev;
  wire word_event = running & samp_rise;
  wire [`AOP_ST_W-1:0] events;
  assign events[`AOP_ST_OVR] = word_event & fmt_over;
  assign events[`AOP_ST_MODE] = (pm_prev != pm_s);
  assign events[`AOP_ST_FMT] = (cf_prev != cf_s);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pm_prev <= 2'h0;
      cf_prev <= 2'h0;
      word_count <= {`AOP_DATA_W{1'b0}};
      last_word <= {WORD_W{1'b0}};
      last_over <= 1'b0;
    end else begin
      pm_prev <= pm_s;
      cf_prev <= cf_s;
      if (word_event) begin
        word_count <= word_count + 1'b1;
        last_word <= fmt_word;
        last_over <= fmt_over;
      end
    end
  end

  // bus slave, one wait state per access
  wire bus_req = read | write;
  assign waitrequest = bus_req & ~bus_ack;
  wire wr_go = write & bus_ack;
  wire [`AOP_ST_W-1:0] st_clear =
    (wr_go && address == `AOP_REG_STATUS) ? writedata[`AOP_ST_W-1:0] : {`AOP_ST_W{1'b0}};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_ack <= 1'b0;
      ctrl <= `AOP_CTRL_RESET;
      mask <= {`AOP_ST_W{1'b0}};
      status <= {`AOP_ST_W{1'b0}};
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      // set wins over clear
      status <= (status & ~st_clear) | events;
      if (wr_go) begin
        case (address)
          `AOP_REG_CTRL: begin
            ctrl <= writedata[1:0];
          end
          `AOP_REG_MASK: begin
            mask <= writedata[`AOP_ST_W-1:0];
          end
          default: begin
            ctrl <= ctrl;
          end
        endcase
      end
    end
  end

  // read data, latched in the wait cycle
  reg [`AOP_DATA_W-1:0] rd_mux;

  always @* begin
    rd_mux = {`AOP_DATA_W{1'b0}};
    case (address)
      `AOP_REG_CTRL: begin
        rd_mux[1:0] = ctrl;
      end
      `AOP_REG_STATUS: begin
        rd_mux[`AOP_ST_W-1:0] = status;
      end
      `AOP_REG_MASK: begin
        rd_mux[`AOP_ST_W-1:0] = mask;
      end
      `AOP_REG_MODE: begin
        rd_mux[`AOP_MODE_NORMAL] = (pstate == ST_NORMAL);
        rd_mux[`AOP_MODE_SLEEP] = (pstate == ST_SLEEP);
        rd_mux[`AOP_MODE_PD] = (pstate == ST_PD);
        rd_mux[`AOP_MODE_DIFF] = diff_sel;
        rd_mux[`AOP_MODE_TWOS] = twos_sel;
        rd_mux[`AOP_MODE_READY] = running;
      end
      `AOP_REG_WORD: begin
        rd_mux[WORD_W-1:0] = last_word;
        rd_mux[WORD_W] = last_over;
      end
      `AOP_REG_COUNT: begin
        rd_mux = word_count;
      end
      default: begin
        rd_mux = {`AOP_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= {`AOP_DATA_W{1'b0}};
    end else if (read & ~bus_ack) begin
      readdata <= rd_mux;
    end
  end

  assign irq = |(status & mask);

endmodule

/* rtl/aop_defs.vh */
`ifndef AOP_DEFS_VH
`define AOP_DEFS_VH

// widths
`define AOP_WORD_W 16
`define AOP_RAW_W 18
`define AOP_ADDR_W 5
`define AOP_DATA_W 32

// strap level codes, two bits per multi-level pin
`define AOP_LVL_GND 2'h0
`define AOP_LVL_THIRD 2'h1
`define AOP_LVL_TWO_THIRDS 2'h2
`define AOP_LVL_FULL 2'h3

// conversion span
`define AOP_CODE_MAX 18'sh0ffff
`define AOP_CODE_MIN 18'sh00000
`define AOP_MSB_FLIP 16'h8000

// register byte addresses
`define AOP_REG_CTRL 5'h00
`define AOP_REG_STATUS 5'h04
`define AOP_REG_MASK 5'h08
`define AOP_REG_MODE 5'h0c
`define AOP_REG_WORD 5'h10
`define AOP_REG_COUNT 5'h14

// ctrl fields and reset value
`define AOP_CTRL_EN 0
`define AOP_CTRL_FORCE_PD 1
`define AOP_CTRL_RESET 2'h1

// status and mask fields
`define AOP_ST_W 3
`define AOP_ST_OVR 0
`define AOP_ST_MODE 1
`define AOP_ST_FMT 2

// mode register fields
`define AOP_MODE_NORMAL 0
`define AOP_MODE_SLEEP 1
`define AOP_MODE_PD 2
`define AOP_MODE_DIFF 3
`define AOP_MODE_TWOS 4
`define AOP_MODE_READY 5

// timing
`define AOP_CLK_NS 100
`define AOP_PD_RECOVER_NS 20000
`define AOP_SLEEP_RECOVER_NS 2000
`define AOP_CNT_W 16

`endif

/* rtl/aop_sync.v */
`timescale 1ns/1ns
module aop_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // asynchronous in, synchronised out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] stage1;

  // stage1 is read only by sync_out
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* rtl/aop_fmt.v */
`timescale 1ns/1ns
`include "aop_defs.vh"
module aop_fmt (
  // raw signed code from the core
  input wire signed [`AOP_RAW_W-1:0] raw_code,
  input wire twos_sel,
  // formatted result
  output reg [`AOP_WORD_W-1:0] word,
  output reg over_range
);

  reg [`AOP_WORD_W-1:0] clamped;

  always @* begin
    clamped = raw_code[`AOP_WORD_W-1:0];
    over_range = (raw_code < `AOP_CODE_MIN) || (raw_code > `AOP_CODE_MAX);
    if (raw_code < `AOP_CODE_MIN) begin
      clamped = {`AOP_WORD_W{1'b0}};
    end else if (raw_code > `AOP_CODE_MAX) begin
      clamped = {`AOP_WORD_W{1'b1}};
    end
    word = twos_sel ? (clamped ^ `AOP_MSB_FLIP) : clamped;
  end

endmodule

/* verif/aop_out_chk.sv */
`timescale 1ns/1ns
module aop_out_chk #(
  parameter WORD_W = 16
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // straps
  input wire [1:0] clock_and_format_pin,
  // output port
  input wire [WORD_W-1:0] conversion_word_lanes_p,
  input wire [WORD_W-1:0] conversion_word_lanes_n,
  input wire over_range_p,
  input wire over_range_n,
  input wire forwarded_word_clock_p,
  input wire forwarded_word_clock_n,
  // core control
  input wire core_sleep,
  input wire core_power_down,
  input wire clock_differential
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_lanes_diff;
    conversion_word_lanes_n == ~conversion_word_lanes_p;
  endproperty
  a_lanes_diff: assert property (p_lanes_diff) else $error("lane pair not complementary");
  property p_fwd_diff;
    forwarded_word_clock_n == ~forwarded_word_clock_p;
  endproperty
  a_fwd_diff: assert property (p_fwd_diff) else $error("word clock pair not complementary");
  property p_word_launch;
    $changed(conversion_word_lanes_p) |-> !forwarded_word_clock_p;
  endproperty
  a_word_launch: assert property (p_word_launch) else $error("word changed in high phase");
  property p_ovr_with_word;
    $changed(over_range_p) |-> !forwarded_word_clock_p && over_range_n == ~over_range_p;
  endproperty
  a_ovr_with_word: assert property (p_ovr_with_word) else $error("flag not launched with word");
  property p_ovr_clamp;
    over_range_p |-> conversion_word_lanes_p inside {16'h0000, 16'hffff, 16'h7fff, 16'h8000};
  endproperty
  a_ovr_clamp: assert property (p_ovr_clamp) else $error("flagged word not at span end");
  property p_pd_park;
    core_power_down && $past(core_power_down) |-> !forwarded_word_clock_p;
  endproperty
  a_pd_park: assert property (p_pd_park) else $error("word clock runs in power-down");
  property p_sleep_park;
    core_sleep && $past(core_sleep) |-> !forwarded_word_clock_p;
  endproperty
  a_sleep_park: assert property (p_sleep_park) else $error("word clock runs in sleep");
  property p_fmt_decode;
    $stable(clock_and_format_pin) [*6] |-> clock_differential == clock_and_format_pin[1];
  endproperty
  a_fmt_decode: assert property (p_fmt_decode) else $error("clock input type wrong");
  c_fwd: cover property ($rose(forwarded_word_clock_p));
  c_ovr: cover property ($rose(over_range_p));
  c_sleep: cover property ($rose(core_sleep));
endmodule

bind aop_top aop_out_chk #(.WORD_W(WORD_W)) i_chk (
  .clk(clk), .nrst(nrst), .clock_and_format_pin(clock_and_format_pin),
  .conversion_word_lanes_p(conversion_word_lanes_p), .conversion_word_lanes_n(conversion_word_lanes_n),
  .over_range_p(over_range_p), .over_range_n(over_range_n),
  .forwarded_word_clock_p(forwarded_word_clock_p), .forwarded_word_clock_n(forwarded_word_clock_n),
  .core_sleep(core_sleep), .core_power_down(core_power_down), .clock_differential(clock_differential)
);

/* verif/aop_cap.sv */
`timescale 1ns/1ns
module aop_cap (
  // differential inputs
  input wire fwd_p,
  input wire fwd_n,
  input wire [15:0] lanes_p,
  input wire [15:0] lanes_n,
  input wire ovr_p,
  input wire ovr_n,
  // captured
  output reg [15:0] word,
  output reg ovr,
  output reg [15:0] cnt
);
  // receiver sees only a true differential high
  wire rx = fwd_p & ~fwd_n;
  initial cnt = 16'h0000;
  always @(posedge rx) begin
    word <= lanes_p & ~lanes_n;
    ovr <= ovr_p & ~ovr_n;
    cnt <= cnt + 16'h0001;
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns
`include "aop_defs.vh"
module tb_top;
  reg clk = 0, nrst = 0, sclk = 0, read = 0, write = 0;
  reg signed [17:0] raw_code = 18'sh00000;
  reg signed [17:0] tbl [0:3];
  reg [1:0] power_mode_pin = 2'h0, clock_and_format_pin = 2'h0;
  reg [4:0] address = 5'h00;
  reg [31:0] writedata = 32'h0, rd;
  wire [15:0] lp, ln, cap_word, cap_cnt;
  wire ovp, ovn, fp, fn, reference_on, core_sleep, core_power_down, clock_differential, irq, waitrequest, cap_ovr;
  wire [31:0] readdata;
  integer mismatches = 0, n_compared = 0, cyc = 0, c, f, i;
  wire sample_clk_n = clock_and_format_pin[1] ? ~sclk : 1'b0;

  aop_top #(.PD_RECOVER_NS(300), .SLEEP_RECOVER_NS(100)) i_dut (
    .clk(clk), .nrst(nrst), .sample_clk_p(sclk), .sample_clk_n(sample_clk_n), .raw_code(raw_code),
    .power_mode_pin(power_mode_pin), .clock_and_format_pin(clock_and_format_pin),
    .conversion_word_lanes_p(lp), .conversion_word_lanes_n(ln), .over_range_p(ovp), .over_range_n(ovn),
    .forwarded_word_clock_p(fp), .forwarded_word_clock_n(fn), .reference_on(reference_on),
    .core_sleep(core_sleep), .core_power_down(core_power_down), .clock_differential(clock_differential),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq)
  );
  aop_cap i_cap (
    .fwd_p(fp), .fwd_n(fn), .lanes_p(lp), .lanes_n(ln), .ovr_p(ovp), .ovr_n(ovn),
    .word(cap_word), .ovr(cap_ovr), .cnt(cap_cnt)
  );

  initial forever #50 clk = ~clk;
  // odd offset keeps link edges off clk edges
  initial begin
    #137;
    forever #400 sclk = ~sclk;
  end

  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  task cmp(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask

  // waitrequest and read data taken at the rising edge, before that edge's updates land
  task bus(input wr, input [4:0] a, input [31:0] d);
    integer k;
    begin
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      k = 0;
      @(posedge clk);
      while (waitrequest !== 1'b0 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      rd = readdata;
      read <= 0;
      write <= 0;
      if (k >= 20) cmp(0, 1);
      @(posedge clk);
    end
  endtask

  task wait_words(input integer n);
    integer k, s;
    begin
      s = cap_cnt;
      k = 0;
      while (cap_cnt < s + n && k < 200) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 200) cmp(0, 1);
    end
  endtask

  function [16:0] expw(input signed [17:0] r, input tw);
    reg [15:0] w;
    begin
      if (r < 0) w = 16'h0000;
      else if (r > 18'sh0ffff) w = 16'hffff;
      else w = r[15:0];
      expw = {(r < 0) || (r > 18'sh0ffff), w ^ (tw ? 16'h8000 : 16'h0000)};
    end
  endfunction

  task t_regs;
    begin
      bus(0, `AOP_REG_CTRL, 0);
      cmp(rd, 32'h1);
      bus(0, `AOP_REG_MASK, 0);
      cmp(rd, 32'h0);
      bus(1, 5'h1c, 32'h5);
      bus(0, 5'h1c, 0);
      cmp(rd, 32'h0);
      $display("t_regs done");
    end
  endtask

  task t_formats;
    begin
      for (f = 0; f < 4; f = f + 1) begin
        clock_and_format_pin <= f[1:0];
        for (i = 0; i < 4; i = i + 1) begin
          raw_code <= tbl[i];
          wait_words(3);
          cmp({cap_ovr, cap_word}, expw(tbl[i], f[0]));
          cmp(clock_differential, f[1]);
        end
      end
      bus(0, `AOP_REG_WORD, 0);
      cmp(rd[16:0], expw(tbl[3], 1'b1));
      clock_and_format_pin <= 2'h0;
      $display("t_formats done");
    end
  endtask

  task t_rate;
    begin
      wait_words(2);
      @(negedge clk);
      c = cap_cnt;
      repeat (80) @(negedge clk);
      cmp(cap_cnt - c, 10);
      @(posedge clk);
      bus(0, `AOP_REG_COUNT, 0);
      i = rd;
      repeat (77) @(posedge clk);
      bus(0, `AOP_REG_COUNT, 0);
      cmp(rd - i, 10);
      $display("t_rate done");
    end
  endtask

  task t_irq;
    begin
      raw_code <= -18'sd1;
      wait_words(3);
      @(negedge clk);
      cmp(irq, 0);
      @(posedge clk);
      bus(1, `AOP_REG_MASK, 1);
      @(negedge clk);
      cmp(irq, 1);
      @(posedge clk);
      raw_code <= 18'sh00100;
      wait_words(3);
      bus(1, `AOP_REG_STATUS, 7);
      @(negedge clk);
      cmp(irq, 0);
      @(posedge clk);
      bus(1, `AOP_REG_MASK, 0);
      $display("t_irq done");
    end
  endtask

  task t_ctrl;
    begin
      bus(1, `AOP_REG_CTRL, 32'h0);
      repeat (12) @(posedge clk);
      bus(0, `AOP_REG_COUNT, 0);
      c = cap_cnt;
      i = rd;
      repeat (40) @(posedge clk);
      cmp(cap_cnt - c, 0);
      bus(0, `AOP_REG_COUNT, 0);
      cmp(rd, i);
      bus(1, `AOP_REG_CTRL, 32'h3);
      repeat (20) @(posedge clk);
      @(negedge clk);
      cmp({core_power_down, reference_on}, 2'h3);
      @(posedge clk);
      bus(0, `AOP_REG_MODE, 0);
      cmp(rd[5:0], 6'h04);
      bus(1, `AOP_REG_CTRL, 32'h1);
      wait_words(2);
      bus(0, `AOP_REG_MODE, 0);
      cmp(rd[5:0], 6'h21);
      $display("t_ctrl done");
    end
  endtask

  task t_power(input [1:0] pin, input [2:0] mode);
    begin
      power_mode_pin <= pin;
      repeat (20) @(posedge clk);
      @(negedge clk);
      c = cap_cnt;
      cmp({core_sleep, core_power_down, reference_on}, {mode[1], mode[2], 1'b1});
      @(posedge clk);
      bus(0, `AOP_REG_MODE, 0);
      cmp(rd[2:0], mode);
      bus(0, `AOP_REG_STATUS, 0);
      cmp(rd[1], 1'b1);
      bus(1, `AOP_REG_STATUS, 32'h2);
      repeat (40) @(negedge clk);
      cmp(cap_cnt - c > 0, mode[0]);
      @(posedge clk);
      $display("t_power done");
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end

  initial begin
    tbl = '{18'sh01234, -18'sd3, 18'sh1ffff, 18'sh0ffff};
    repeat (6) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_regs;
    t_formats;
    t_rate;
    t_irq;
    t_ctrl;
    t_power(2'h3, 3'b100);
    t_power(2'h2, 3'b010);
    t_power(2'h0, 3'b001);
    complete_run;
  end
endmodule
